//--- design/dbs_debug_scan.sv
`timescale 1ns/1ps
// How it works
// - Access chain: rw, 5 address, 32 data
// - Capture leaves access chain contents unchanged
// - Shift loads chain; bits 32-36 address
// - Update writes if bit 37, else reads
// - External drive and clocks only while chain 3
// - Test drive on INTEST/EXTEST/CLAMP/clamp-tristate
// - Update clock pulses in update-data state
// - Capture clocks pulse per INTEST or EXTEST
// - Two non-overlapping shift clocks, else low
// - Tristate request low only under HIGHZ
// - External reset active in Test-Logic-Reset
// - Normal: memory clock, debug clock low
// - Debug: debug clock drives core, exported
// - Monitor mode blocks debug entry, not serial test
// - Acknowledge in high phase, switch on fall
// - Restart resynchronises core to memory clock
// - Test clock in idle, chain 0 INTEST
// - Status bit 4 marks compressed-state entry
// - External path for chain 3 or unassigned
// - Selected chain number on four-bit output
module dbs_debug_scan #(
  parameter int NREG = 8 // Debug registers held in the access chain target
) (
  input wire logic clk_i, // 25 MHz system clock
  input wire logic rst_i, // Synchronous reset, active high
  // Wishbone slave
  input wire logic cyc_i, // Bus cycle
  input wire logic stb_i, // Strobe
  input wire logic we_i, // Write enable
  input wire logic [7:0] adr_i, // Byte address
  input wire logic [3:0] sel_i, // Byte lanes
  input wire logic [31:0] dat_i, // Write data
  output logic [31:0] dat_o, // Read data
  output logic ack_o, // Acknowledge
  // Test pins from the debug host
  input wire logic tck_i, // Test clock pin
  input wire logic tdi_i, // Test data in pin
  output logic tdo_o, // Test data out
  // Decoded TAP state, same clock domain
  input wire logic st_tlr_i, // Test-Logic-Reset
  input wire logic st_rti_i, // Run-Test/Idle
  input wire logic st_capture_dr_i, // Capture-data
  input wire logic st_shift_dr_i, // Shift-data
  input wire logic st_update_dr_i, // Update-data
  // Decoded current instruction, same clock domain
  input wire logic ir_intest_i, // INTEST current
  input wire logic ir_extest_i, // EXTEST current
  input wire logic ir_clamp_i, // CLAMP current
  input wire logic ir_clamp_tristate_instr_i, // Clamp-with-tristate current
  input wire logic ir_highz_i, // HIGHZ loaded
  input wire logic ir_restart_i, // RESTART current
  input wire logic [3:0] chain_sel_i, // Chain chosen by the scan path select
  // Core side
  input wire logic mclk_i, // Memory clock pin
  input wire logic debug_req_i, // Core wants to enter debug
  input wire logic compact_i, // Core is in compressed state
  output logic debug_acknowledge_o, // Core is in debug state
  output logic debug_clock_o, // Debug clock
  output logic exported_core_clock_o, // Selected core clock
  output logic [3:0] selected_chain_number_o, // Current chain
  // External boundary-scan chain
  input wire logic ext_scan_return_in_i, // Serial data back from chain
  output logic ext_scan_data_out_o, // Serial data to chain
  output logic ext_chain_test_drive_o, // Cells in test mode
  output logic ext_chain_update_clk_o, // Update clock
  output logic ext_chain_intest_capture_clk_o, // INTEST capture clock
  output logic ext_chain_extest_capture_clk_o, // EXTEST capture clock
  output logic ext_chain_shift_master_clk_o, // Master shift clock
  output logic ext_chain_shift_slave_clk_o, // Slave shift clock
  output logic tristate_request_n_o, // Tristate request, active low
  output logic ext_chain_reset_o // External cell reset
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [dbs_pkg::PIN_N-1:0] s1; // First sync stage
    logic [dbs_pkg::PIN_N-1:0] s2; // Second sync stage
    logic [dbs_pkg::PIN_N-1:0] s3; // Third sync stage
    logic [dbs_pkg::PIN_N-1:0] pin; // Filtered pin levels
    logic tck_d; // Filtered test clock, one cycle late
    logic mclk_d; // Filtered memory clock, one cycle late
    logic [dbs_pkg::CHAIN_LEN-1:0] sr; // Access chain shift register
    logic [NREG-1:0][dbs_pkg::DATA_W-1:0] regs; // Debug registers
    logic tdo; // Serial out
    logic ext_out; // Data to external chain
    logic drive; // Test drive
    logic upd_clk; // Update clock
    logic icap; // INTEST capture clock
    logic ecap; // EXTEST capture clock
    logic sh_m; // Master shift clock
    logic sh_s; // Slave shift clock
    logic hz_n; // Tristate request
    logic ext_rst; // External reset
    logic dbg_clk; // Debug clock
    logic core_clk; // Exported core clock
    logic dbg_ack; // Debug acknowledge
    logic compact; // Debug entered from compressed state
    logic mon; // Monitor mode selected
    logic test; // Serial test requested
    dbs_pkg::dbs_clk_mode_t mode; // Clock selection mode
    logic [3:0] chain; // Selected chain
    logic wb_ack; // Bus acknowledge
    logic [31:0] wb_dat; // Bus read data
  } dbs_state_t;

  dbs_state_t r; // Registered state
  dbs_state_t next_r; // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // True for chain numbers routed to the external scan pins
  function automatic logic is_ext_path(input logic [3:0] c);
    is_ext_path = !(c == dbs_pkg::CHAIN_CORE || c == dbs_pkg::CHAIN_DEBUG ||
                    c == dbs_pkg::CHAIN_REGS || c == dbs_pkg::CHAIN_RSV_A ||
                    c == dbs_pkg::CHAIN_RSV_B);
  endfunction

  // Word decode shared by the bus read and write paths
  function automatic logic adr_is(input logic [7:0] a, input logic [7:0] ofs);
    adr_is = (a[7:2] == ofs[7:2]);
  endfunction

  logic tck_rise; // Filtered test clock rising edge
  logic tck_hi; // Test clock high for two samples
  logic tck_lo; // Test clock low for two samples
  logic mclk_hi; // Memory clock high phase
  logic mclk_fall; // Memory clock falling edge
  logic on_chain3; // External controls may act
  logic regs_ok; // Access chain updates allowed
  logic [dbs_pkg::ADDR_W-1:0] acc_adr; // Addressed debug register
  logic [31:0] stat_word; // Bus status view
  logic [31:0] dstat_word; // Debug status register view
  logic bus_req; // New bus request

  assign tck_hi = r.pin[dbs_pkg::PIN_TCK] & r.tck_d;
  assign tck_lo = ~r.pin[dbs_pkg::PIN_TCK] & ~r.tck_d;
  assign tck_rise = r.pin[dbs_pkg::PIN_TCK] & ~r.tck_d;
  assign mclk_hi = r.pin[dbs_pkg::PIN_MCLK];
  assign mclk_fall = ~r.pin[dbs_pkg::PIN_MCLK] & r.mclk_d;
  assign on_chain3 = (r.chain == dbs_pkg::CHAIN_EXT);
  assign regs_ok = (r.chain == dbs_pkg::CHAIN_REGS) & ir_intest_i;
  assign acc_adr = r.sr[dbs_pkg::ADDR_LSB +: dbs_pkg::ADDR_W];
  assign bus_req = cyc_i & stb_i & ~r.wb_ack;

  // Hardware status words
  always_comb
  begin
    dstat_word = 32'h0000_0000;
    dstat_word[dbs_pkg::DSTAT_ACK_BIT] = r.dbg_ack;
    dstat_word[dbs_pkg::DSTAT_COMPACT_BIT] = r.compact;
    stat_word = 32'h0000_0000;
    stat_word[dbs_pkg::STAT_ACK_BIT] = r.dbg_ack;
    // Either test-clock mode counts as debug clock selected
    stat_word[dbs_pkg::STAT_DSEL_BIT] = (r.mode == dbs_pkg::CLK_DEBUG) |
                                        (r.mode == dbs_pkg::CLK_TEST);
    stat_word[dbs_pkg::STAT_TEST_BIT] = r.test;
    stat_word[dbs_pkg::STAT_COMPACT_BIT] = r.compact;
    stat_word[dbs_pkg::STAT_CHAIN_LSB +: 4] = r.chain;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    next_r = r;
    // Pin sampling; a change counts once stages two and three agree
    next_r.s1 = {ext_scan_return_in_i, mclk_i, tdi_i, tck_i};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < dbs_pkg::PIN_N; i++)
    begin
      if (r.s2[i] == r.s3[i])
      begin
        next_r.pin[i] = r.s3[i];
      end
    end
    next_r.tck_d = r.pin[dbs_pkg::PIN_TCK];
    next_r.mclk_d = r.pin[dbs_pkg::PIN_MCLK];
    next_r.chain = chain_sel_i;

    // Access chain: captures nothing, shifts toward the low end
    if (tck_rise && st_shift_dr_i && r.chain == dbs_pkg::CHAIN_REGS)
    begin
      next_r.sr = {r.pin[dbs_pkg::PIN_TDI], r.sr[dbs_pkg::CHAIN_LEN-1:1]};
    end
    else if (tck_rise && st_update_dr_i && regs_ok)
    begin
      if (r.sr[dbs_pkg::RW_BIT])
      begin
        // Status is hardware owned; writes to it are dropped
        if (acc_adr != dbs_pkg::DSTAT_ADDR && 32'(acc_adr) < NREG)
        begin
          next_r.regs[acc_adr] = r.sr[dbs_pkg::DATA_W-1:0];
        end
      end
      else if (acc_adr == dbs_pkg::DSTAT_ADDR)
      begin
        next_r.sr[dbs_pkg::DATA_W-1:0] = dstat_word;
      end
      else if (32'(acc_adr) < NREG)
      begin
        next_r.sr[dbs_pkg::DATA_W-1:0] = r.regs[acc_adr];
      end
      else
      begin
        next_r.sr[dbs_pkg::DATA_W-1:0] = 32'h0000_0000;
      end
    end
    // Capture-data on this chain deliberately has no branch

    // Serial out registered every cycle from the chain end, chosen by chain
    if (r.chain == dbs_pkg::CHAIN_REGS)
    begin
      next_r.tdo = r.sr[0];
    end
    else if (is_ext_path(r.chain))
    begin
      next_r.tdo = r.pin[dbs_pkg::PIN_RET];
    end
    else
    begin
      next_r.tdo = 1'b0;
    end
    next_r.ext_out = is_ext_path(r.chain) & r.pin[dbs_pkg::PIN_TDI];

    // External chain controls; drive and clocks held inactive off chain 3
    next_r.drive = on_chain3 & (ir_intest_i | ir_extest_i | ir_clamp_i |
                                ir_clamp_tristate_instr_i);
    next_r.upd_clk = on_chain3 & st_update_dr_i & tck_hi;
    next_r.icap = on_chain3 & st_capture_dr_i & ir_intest_i & tck_hi;
    next_r.ecap = on_chain3 & st_capture_dr_i & ir_extest_i & tck_hi;
    // A one-sample gap at each test clock edge keeps the two apart
    next_r.sh_m = on_chain3 & st_shift_dr_i & tck_hi;
    next_r.sh_s = on_chain3 & st_shift_dr_i & tck_lo;
    next_r.hz_n = ~ir_highz_i;
    next_r.ext_rst = st_tlr_i;

    // Core clock mode
    unique case (r.mode)
      dbs_pkg::CLK_NORMAL:
      begin
        // Monitor mode blocks debug entry; serial test still leaves the memory clock
        if (debug_req_i && !r.mon && mclk_hi)
        begin
          next_r.dbg_ack = 1'b1;
          next_r.compact = compact_i;
          next_r.mode = dbs_pkg::CLK_ENTRY;
        end
        else if (r.test)
        begin
          next_r.mode = dbs_pkg::CLK_TEST;
        end
      end
      dbs_pkg::CLK_ENTRY:
      begin
        if (mclk_fall)
        begin
          next_r.mode = dbs_pkg::CLK_DEBUG;
        end
      end
      dbs_pkg::CLK_DEBUG:
      begin
        // Resync happens when restart reaches idle
        if (ir_restart_i && st_rti_i)
        begin
          next_r.dbg_ack = 1'b0;
          next_r.mode = dbs_pkg::CLK_NORMAL;
        end
      end
      dbs_pkg::CLK_TEST:
      begin
        if (ir_restart_i)
        begin
          next_r.test = 1'b0;
          next_r.mode = dbs_pkg::CLK_NORMAL;
        end
      end
    endcase

    // Debug clock from the test clock, only in idle
    next_r.dbg_clk = 1'b0;
    if (r.mode == dbs_pkg::CLK_DEBUG)
    begin
      next_r.dbg_clk = st_rti_i & ir_intest_i & tck_hi;
    end
    else if (r.mode == dbs_pkg::CLK_TEST)
    begin
      // External test never clocks the core
      next_r.dbg_clk = st_rti_i & ir_intest_i & ~ir_extest_i & tck_hi &
                       (r.chain == dbs_pkg::CHAIN_CORE);
    end
    // Memory clock path adds two samples, same as debug clock path
    if (r.mode == dbs_pkg::CLK_DEBUG || r.mode == dbs_pkg::CLK_TEST)
    begin
      next_r.core_clk = r.dbg_clk;
    end
    else
    begin
      next_r.core_clk = r.mclk_d;
    end

    // Wishbone: ack one cycle after a new request, dropped next cycle
    next_r.wb_ack = bus_req;
    next_r.wb_dat = 32'h0000_0000;
    // Writes land at the edge where the master samples ack high, not earlier
    if (cyc_i && stb_i && r.wb_ack && we_i && sel_i[0] && adr_is(adr_i, dbs_pkg::CTRL_OFS))
    begin
      next_r.mon = dat_i[dbs_pkg::CTRL_MON_BIT];
      next_r.test = dat_i[dbs_pkg::CTRL_TEST_BIT];
    end
    else if (bus_req && !we_i && adr_is(adr_i, dbs_pkg::CTRL_OFS))
    begin
      next_r.wb_dat[dbs_pkg::CTRL_MON_BIT] = r.mon;
      next_r.wb_dat[dbs_pkg::CTRL_TEST_BIT] = r.test;
    end
    else if (bus_req && !we_i && adr_is(adr_i, dbs_pkg::STAT_OFS))
    begin
      next_r.wb_dat = stat_word;
    end

    // Synchronous reset
    if (rst_i)
    begin
      next_r = '0;
      next_r.hz_n = 1'b1;
      next_r.mode = dbs_pkg::CLK_NORMAL;
      next_r.chain = dbs_pkg::CHAIN_RESET;
      next_r.mon = dbs_pkg::CTRL_RESET[dbs_pkg::CTRL_MON_BIT];
      next_r.test = dbs_pkg::CTRL_RESET[dbs_pkg::CTRL_TEST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Single state register
  always_ff @(posedge clk_i)
  begin
    r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign dat_o = r.wb_dat;
  assign ack_o = r.wb_ack;
  assign tdo_o = r.tdo;
  assign debug_acknowledge_o = r.dbg_ack;
  assign debug_clock_o = r.dbg_clk;
  assign exported_core_clock_o = r.core_clk;
  assign selected_chain_number_o = r.chain;
  assign ext_scan_data_out_o = r.ext_out;
  assign ext_chain_test_drive_o = r.drive;
  assign ext_chain_update_clk_o = r.upd_clk;
  assign ext_chain_intest_capture_clk_o = r.icap;
  assign ext_chain_extest_capture_clk_o = r.ecap;
  assign ext_chain_shift_master_clk_o = r.sh_m;
  assign ext_chain_shift_slave_clk_o = r.sh_s;
  assign tristate_request_n_o = r.hz_n;
  assign ext_chain_reset_o = r.ext_rst;

endmodule

//--- inc/dbs_pkg.sv
package dbs_pkg;

  // Scan chain numbers
  localparam logic [3:0] CHAIN_CORE = 4'h0;
  localparam logic [3:0] CHAIN_DEBUG = 4'h1;
  localparam logic [3:0] CHAIN_REGS = 4'h2;
  localparam logic [3:0] CHAIN_EXT = 4'h3;
  localparam logic [3:0] CHAIN_RSV_A = 4'h4;
  localparam logic [3:0] CHAIN_RSV_B = 4'h8;
  localparam logic [3:0] CHAIN_RESET = 4'h0;

  // Debug register access chain layout
  localparam int CHAIN_LEN = 38;
  localparam int RW_BIT = 37;
  localparam int ADDR_LSB = 32;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // Debug status register, reached through the access chain
  localparam logic [4:0] DSTAT_ADDR = 5'h01;
  localparam int DSTAT_ACK_BIT = 0;
  localparam int DSTAT_COMPACT_BIT = 4;

  // Wishbone register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;

  // Control register fields
  localparam int CTRL_MON_BIT = 0;
  localparam int CTRL_TEST_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register fields
  localparam int STAT_ACK_BIT = 0;
  localparam int STAT_DSEL_BIT = 1;
  localparam int STAT_TEST_BIT = 2;
  localparam int STAT_COMPACT_BIT = 4;
  localparam int STAT_CHAIN_LSB = 8;

  // Pin synchroniser: bit positions in the sampled vector
  localparam int PIN_N = 4;
  localparam int PIN_TCK = 0;
  localparam int PIN_TDI = 1;
  localparam int PIN_MCLK = 2;
  localparam int PIN_RET = 3;

  // Core clock selection modes
  typedef enum logic [1:0] {
    CLK_NORMAL,
    CLK_ENTRY,
    CLK_DEBUG,
    CLK_TEST
  } dbs_clk_mode_t;

endpackage

//--- sim/dbs_host.sv
`timescale 1ns/1ps
module dbs_host (
  input wire logic clk_i, // System clock
  input wire logic tdo_i, // Serial data from block
  output logic tck_o, // Test clock, 320 ns
  output logic tdi_o // Test data
);
  logic [63:0] cap = 64'h0; // Bits seen before each rise
  initial tck_o = 1'b0;
  initial tdi_o = 1'b0;
  //////////////////////////////////////////////////////////////////
  // Clock n bits, LSB first; clock stands still between frames
  task automatic run(input int n, input logic [63:0] d);
    for (int i = 0; i < n; i++)
    begin
      tdi_o <= d[i];
      tck_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      cap[i] = tdo_i;
      @(posedge clk_i);
      tck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
    tck_o <= 1'b0;
    // Released line shows no stale value
    tdi_o <= ~tdi_o;
    @(posedge clk_i);
  endtask
endmodule

//--- sim/dbs_properties.sv
`timescale 1ns/1ps
module dbs_props (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic cyc_i, // Bus cycle
  input wire logic stb_i, // Strobe
  input wire logic ack_o, // Bus answer
  input wire logic st_tlr_i, // Test-Logic-Reset
  input wire logic st_rti_i, // Run-Test/Idle
  input wire logic st_capture_dr_i, // Capture-data
  input wire logic st_shift_dr_i, // Shift-data
  input wire logic st_update_dr_i, // Update-data
  input wire logic ir_highz_i, // HIGHZ loaded
  input wire logic [3:0] chain_sel_i, // Chain chosen
  input wire logic [3:0] selected_chain_number_o, // Chain shown
  input wire logic debug_clock_o, // Debug clock
  input wire logic tristate_request_n_o, // Tristate request
  input wire logic ext_chain_reset_o, // External reset
  input wire logic ext_chain_test_drive_o, // Test drive
  input wire logic ext_chain_update_clk_o, // Update clock
  input wire logic ext_chain_intest_capture_clk_o, // Internal capture
  input wire logic ext_chain_extest_capture_clk_o, // External capture
  input wire logic ext_chain_shift_master_clk_o, // Master shift
  input wire logic ext_chain_shift_slave_clk_o // Slave shift
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic up; // Past values are clean of reset
  //////////////////////////////////////////////////////////////////
  // Guard so a one-cycle $past never looks into the reset cycle
  always_ff @(posedge clk_i)
    up <= !rst_i;
  sequence wb_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence ack_pulse;
    ack_o ##1 !ack_o;
  endsequence
  //////////////////////////////////////////////////////////////////
  bus_ack_a: assert property (wb_req |=> ack_pulse)
    else $error("bus answer late or long");
  highz_out_a: assert property (up |-> tristate_request_n_o == !$past(ir_highz_i))
    else $error("tristate request wrong");
  ext_reset_a: assert property (up |-> ext_chain_reset_o == $past(st_tlr_i))
    else $error("external reset wrong");
  chain_out_a: assert property (up |-> selected_chain_number_o == $past(chain_sel_i))
    else $error("chain number wrong");
  ext_gate_a: assert property (up && $past(chain_sel_i) != 4'h3
    && $past(chain_sel_i, 2) != 4'h3 |-> !(ext_chain_test_drive_o || ext_chain_update_clk_o
    || ext_chain_intest_capture_clk_o || ext_chain_extest_capture_clk_o
    || ext_chain_shift_master_clk_o || ext_chain_shift_slave_clk_o))
    else $error("external control active off chain");
  shift_split_a: assert property (!(ext_chain_shift_master_clk_o
    && ext_chain_shift_slave_clk_o)) else $error("shift clocks overlap");
  shift_idle_a: assert property (up && !$past(st_shift_dr_i) |->
    !ext_chain_shift_master_clk_o && !ext_chain_shift_slave_clk_o)
    else $error("shift clock outside shift");
  cap_idle_a: assert property (up && !$past(st_capture_dr_i) |->
    !ext_chain_intest_capture_clk_o && !ext_chain_extest_capture_clk_o)
    else $error("capture clock outside capture");
  upd_idle_a: assert property (up && !$past(st_update_dr_i) |-> !ext_chain_update_clk_o)
    else $error("update clock outside update");
  debug_clock_idle_a: assert property (up && !$past(st_rti_i) |-> !debug_clock_o)
    else $error("debug clock outside idle");
endmodule
bind dbs_debug_scan dbs_props u_props (.*);

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk_i, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus side
  logic dreq = 1'b0, compact = 1'b0, mc_en = 1'b1; // Core side
  logic [7:0] adr = 8'h00; // Byte address
  logic [31:0] dat = 32'h0, rd, q; // Bus data
  logic [3:0] chain = 4'h0, scn; // Chain in and out
  logic [4:0] st = 5'h00; // State: tlr rti cap shift upd
  logic [5:0] ir = 6'h00; // restart highz clamp_tristate_instr clamp extest intest
  logic [2:0] mc = 3'h0; // Memory clock divider
  logic tck, tdi, tdo, ack, sdo, drv, tri_n, xrst, dbg; // Pins
  logic [6:0] mon; // Watched clock outputs
  int cnt[7]; // High cycles seen per output
  int err_total, checks;
  dbs_debug_scan DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(rd), .ack_o(ack), .tck_i(tck),
    .tdi_i(tdi), .tdo_o(tdo), .st_tlr_i(st[4]), .st_rti_i(st[3]), .st_capture_dr_i(st[2]),
    .st_shift_dr_i(st[1]), .st_update_dr_i(st[0]), .ir_intest_i(ir[0]), .ir_extest_i(ir[1]),
    .ir_clamp_i(ir[2]), .ir_clamp_tristate_instr_i(ir[3]), .ir_highz_i(ir[4]),
    .ir_restart_i(ir[5]), .chain_sel_i(chain), .mclk_i(mc[2] & mc_en), .debug_req_i(dreq),
    .compact_i(compact), .debug_acknowledge_o(dbg), .debug_clock_o(mon[5]),
    .exported_core_clock_o(mon[6]), .selected_chain_number_o(scn),
    .ext_scan_return_in_i(sdo), .ext_scan_data_out_o(sdo), .ext_chain_test_drive_o(drv),
    .ext_chain_update_clk_o(mon[2]), .ext_chain_intest_capture_clk_o(mon[3]),
    .ext_chain_extest_capture_clk_o(mon[4]), .ext_chain_shift_master_clk_o(mon[0]),
    .ext_chain_shift_slave_clk_o(mon[1]), .tristate_request_n_o(tri_n),
    .ext_chain_reset_o(xrst)); // Zero-length external chain loops back
  dbs_host host (.clk_i(clk_i), .tdo_i(tdo), .tck_o(tck), .tdi_o(tdi));
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Free-running memory clock and pulse counters
  always @(posedge clk_i)
  begin
    mc <= mc + 3'h1;
    for (int k = 0; k < 7; k++) cnt[k] += int'(mon[k] === 1'b1);
  end
  //////////////////////////////////////////////////////////////////
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic clr;
    @(negedge clk_i);
    foreach (cnt[k]) cnt[k] = 0;
  endtask
  task automatic go(input logic [3:0] c, input logic [5:0] i, input logic [4:0] s);
    @(posedge clk_i);
    chain <= c;
    ir <= i;
    st <= s;
    repeat (3) @(posedge clk_i);
  endtask
  // Classic single cycle, waits for the answer with no bound of its own
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    // Only the watchdog bounds this wait
    while (ack !== 1'b1)
    begin
      n++;
      @(posedge clk_i);
    end
    q = rd;
    cmp("bus wait", 1, n);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic acc(input logic rw, input logic [4:0] a, input logic [31:0] d,
    input logic [5:0] i);
    go(4'h2, i, 5'h02);
    host.run(38, {26'h0, rw, a, d});
    go(4'h2, i, 5'h01);
    host.run(1, 64'h0);
    go(4'h2, i, 5'h08);
  endtask
  task automatic rdchk(input string n, input logic [31:0] e);
    go(4'h2, 6'h01, 5'h04);
    host.run(1, 64'h0);
    go(4'h2, 6'h01, 5'h02);
    host.run(32, 64'h0);
    cmp(n, e, host.cap[31:0]);
  endtask
  task automatic waitack(input logic v);
    for (int t = 0; t < 40 && dbg !== v; t++) @(posedge clk_i);
    cmp("debug acknowledge", v, dbg);
  endtask
  // External chain controls for chain 3 and an unassigned chain
  task automatic ext(input logic [3:0] c);
    logic on;
    on = (c == 4'h3);
    for (int k = 0; k < 4; k++)
    begin
      go(c, 6'(6'h01 << k), 5'h08);
      cmp("test drive", on, drv);
    end
    go(c, 6'h02, 5'h02);
    clr();
    host.run(4, 64'hF);
    cmp("return path", 2'b11, host.cap[3:2]);
    go(c, 6'h02, 5'h04);
    host.run(1, 64'h0);
    go(c, 6'h01, 5'h04);
    host.run(1, 64'h0);
    go(c, 6'h01, 5'h01);
    host.run(1, 64'h0);
    cmp("shift clocks", {on, on}, {cnt[0] > 0, cnt[1] > 0});
    cmp("capture clocks", {on, on}, {cnt[3] > 0, cnt[4] > 0});
    cmp("update clock", on, cnt[2] > 0);
  endtask
  // Serial test: memory clock held low, debug clock only in idle under INTEST
  task automatic tmode;
    mc_en <= 1'b0;
    wb(1'b1, dbs_pkg::CTRL_OFS, 32'h2);
    go(4'h0, 6'h01, 5'h08);
    wb(1'b0, dbs_pkg::STAT_OFS, 32'h0);
    cmp("test status", 32'h16, q);
    clr();
    host.run(2, 64'h0);
    // Let the last debug clock pulse drain before counting
    repeat (8) @(posedge clk_i);
    cmp("test debug clock", 1'b1, cnt[5] > 0);
    cmp("test core clock", cnt[5], cnt[6]);
    go(4'h0, 6'h02, 5'h08);
    clr();
    host.run(2, 64'h0);
    cmp("extest debug clock", 0, cnt[5]);
    go(4'h0, 6'h20, 5'h08);
    mc_en <= 1'b1;
    wb(1'b0, dbs_pkg::STAT_OFS, 32'h0);
    cmp("test left", 32'h10, q);
  endtask
  task automatic conclude;
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (30000) @(posedge clk_i);
    err_total++;
    conclude();
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    cmp("reset pins", 6'h20, {tri_n, xrst, scn});
    go(4'h5, 6'h10, 5'h10);
    cmp("highz pins", 6'h15, {tri_n, xrst, scn});
    wb(1'b1, dbs_pkg::CTRL_OFS, 32'h1);
    wb(1'b1, 8'hF0, 32'hFFFF);
    wb(1'b0, 8'hF0, 32'h0);
    cmp("unmapped read", 32'h0, q);
    dreq <= 1'b1;
    repeat (40) @(posedge clk_i);
    cmp("monitor mode stays", 1'b0, dbg);
    dreq <= 1'b0;
    wb(1'b1, dbs_pkg::CTRL_OFS, 32'h0);
    acc(1'b1, 5'h02, 32'h12345678, 6'h01);
    acc(1'b1, 5'h02, 32'hA5A5A5A5, 6'h02);
    acc(1'b0, 5'h02, 32'h0, 6'h01);
    rdchk("register data", 32'h12345678);
    go(4'h2, 6'h01, 5'h08);
    clr();
    host.run(4, 64'h0);
    cmp("normal debug clock", 0, cnt[5]);
    cmp("normal core clock", 1'b1, cnt[6] > 0);
    compact <= 1'b1;
    // No wait line here: the core is never stalled while in debug
    dreq <= 1'b1;
    waitack(1'b1);
    dreq <= 1'b0;
    clr();
    host.run(4, 64'h0);
    cmp("debug clock runs", 1'b1, cnt[5] > 0);
    wb(1'b0, dbs_pkg::STAT_OFS, 32'h0);
    cmp("status word", 32'h213, q);
    acc(1'b0, dbs_pkg::DSTAT_ADDR, 32'h0, 6'h01);
    rdchk("debug status", 32'h11);
    go(4'h2, 6'h20, 5'h08);
    waitack(1'b0);
    ext(4'h3);
    ext(4'h5);
    tmode();
    conclude();
  end
endmodule
